// ---- tb/fpf_ctrl_bench.sv ----
// self-checking bench for the phase and fifo sequencer
`timescale 1ns/1ns
module fpf_ctrl_bench;
   logic clk, reset, read_strobe_n, write_strobe_n, data_oe_n, dma_acknowledge_n, terminal_count;
   logic dma_request, irq, interface_select, disk_byte_valid, disk_sector_last, disk_take, disk_done;
   logic write_protect_in, track_zero_input, head_select_output, cfg_load, cfg_fifo_en, spec_load;
   logic spec_non_dma, cmd_is_write, cmd_has_exec, core_reset, polling_en;
   logic [2:0] addr;
   logic [1:0] drive_select_bits;
   logic [3:0] cfg_fifo_threshold_field;
   logic [7:0] data_in, data_out, disk_byte, id_track, cur_track, disk_wr_byte, q;
   fpf_pkg::fpf_err_s disk_err, err_v;
   logic [7:0] buf_q[$];
   int bad_count, checks, thr;
   logic [31:0] seed_v;
   // ********
   // device and far side
   // ********
   fpf_ctrl uut (.clk(clk), .reset(reset), .addr(addr), .read_strobe_n(read_strobe_n),
      .write_strobe_n(write_strobe_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .dma_acknowledge_n(dma_acknowledge_n), .terminal_count(terminal_count), .dma_request(dma_request),
      .irq(irq), .interface_select(interface_select), .disk_byte_valid(disk_byte_valid),
      .disk_byte(disk_byte), .disk_sector_last(disk_sector_last), .disk_take(disk_take),
      .disk_done(disk_done), .disk_err(disk_err), .id_track(id_track), .cur_track(cur_track),
      .write_protect_in(write_protect_in), .track_zero_input(track_zero_input),
      .head_select_output(head_select_output), .drive_select_bits(drive_select_bits),
      .cfg_load(cfg_load), .cfg_fifo_en(cfg_fifo_en), .cfg_fifo_threshold_field(cfg_fifo_threshold_field),
      .spec_load(spec_load), .spec_non_dma(spec_non_dma), .cmd_is_write(cmd_is_write),
      .cmd_has_exec(cmd_has_exec), .disk_wr_byte(disk_wr_byte), .core_reset(core_reset),
      .polling_en(polling_en));
   fpf_host host (.clk(clk), .addr(addr), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .data_in(data_in), .dma_acknowledge_n(dma_acknowledge_n), .terminal_count(terminal_count),
      .data_out(data_out));
   // clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ********
   // checking and expectations
   // ********
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [7:0] st0_exp(input logic [1:0] ic);
      return {ic, 3'b000, head_select_output, drive_select_bits};
   endfunction
   function automatic logic [7:0] st1_exp(input fpf_pkg::fpf_err_s e, input logic tc);
      return {e.end_of_track | !tc, 1'b0, e.id_crc | e.data_crc, 2'b00, e.no_data, e.wp_hit,
              e.no_id_mark | e.no_data_mark};
   endfunction
   function automatic logic [7:0] st2_exp(input fpf_pkg::fpf_err_s e);
      return {1'b0, e.mark_mismatch, e.data_crc, id_track != cur_track, 2'b00,
              (id_track != cur_track) && (id_track == fpf_pkg::BAD_TRACK), e.no_data_mark};
   endfunction
   function automatic logic [7:0] st3_exp();
      return {1'b0, write_protect_in, 1'b1, track_zero_input, 1'b1, head_select_output, drive_select_bits};
   endfunction
   // ********
   // stimulus helpers
   // ********
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      host.cyc(1'b0, a, d, 1'b0, 1'b0, q);
   endtask
   task automatic rd(input logic [2:0] a);
      host.cyc(1'b1, a, 8'h00, 1'b0, 1'b0, q);
   endtask
   task automatic wait_rqm(input logic transfer_direction_flag);
      for (int i = 0; i < 40; i++) begin
         rd(fpf_pkg::ADDR_MSR_DSR);
         if (q[7:6] === {1'b1, transfer_direction_flag}) break;
      end
      chk({6'h00, q[7:6]}, {6'h00, 1'b1, transfer_direction_flag});
   endtask
   task automatic cmd(input logic is_wr, input logic [3:0] fld);
      @(negedge clk);
      cfg_load = 1'b1;
      cfg_fifo_threshold_field = fld;
      cmd_is_write = is_wr;
      @(negedge clk);
      cfg_load = 1'b0;
      for (int i = 0; i < 9; i++) begin
         wait_rqm(1'b0);
         wr(fpf_pkg::ADDR_DATA, 8'(i + 1));
      end
   endtask
   task automatic pop();
      chk(disk_wr_byte, buf_q.pop_front());
      @(negedge clk);
      disk_take = 1'b1;
      @(negedge clk);
      disk_take = 1'b0;
   endtask
   task automatic results(input logic [1:0] ic, input logic tc);
      logic [7:0] e[5];
      @(negedge clk);
      disk_err = err_v;
      @(negedge clk);
      disk_err = '0;
      disk_done = 1'b1;
      @(negedge clk);
      disk_done = 1'b0;
      for (int i = 0; i < 40 && irq !== 1'b1; i++) idle(1);
      chk({7'h00, irq}, 8'h01);
      e = '{st0_exp(ic), st1_exp(err_v, tc), st2_exp(err_v), st3_exp(), cur_track};
      for (int i = 0; i < 7; i++) begin
         wait_rqm(1'b1);
         rd(fpf_pkg::ADDR_DATA);
         if (i < 5) chk(q, e[i]);
      end
      rd(fpf_pkg::ADDR_MSR_DSR);
      chk({4'h0, q[7:4]}, 8'h08);
   endtask
   // ********
   // watchdog
   // ********
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
   // ********
   // main sequence
   // ********
   initial begin
      seed_v = $urandom(32'hF5E9511E);
      {reset, interface_select, cfg_fifo_en, cmd_has_exec} = 4'hF;
      {disk_byte_valid, disk_sector_last, disk_take, disk_done, cfg_load, spec_load} = 6'h00;
      {spec_non_dma, cmd_is_write, cfg_fifo_threshold_field, disk_byte} = 14'h0000;
      {write_protect_in, track_zero_input, head_select_output, drive_select_bits} = 5'($urandom);
      disk_err = '0;
      err_v = '0;
      cur_track = 8'($urandom_range(254, 0));
      id_track = 8'hFF;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      idle(2);
      chk({7'h00, core_reset}, 8'h01);
      wr(fpf_pkg::ADDR_DOR, 8'h0C);
      idle(3);
      chk({6'h00, core_reset, polling_en}, 8'h01);
      // rate reset in mid-command
      wait_rqm(1'b0);
      wr(fpf_pkg::ADDR_DATA, 8'h46);
      wr(fpf_pkg::ADDR_MSR_DSR, 8'h80);
      idle(4);
      rd(fpf_pkg::ADDR_MSR_DSR);
      chk({4'h0, q[7:4]}, 8'h08);
      chk({7'h00, core_reset}, 8'h00);
      wr(fpf_pkg::ADDR_DOR, 8'h08);
      wr(fpf_pkg::ADDR_MSR_DSR, 8'h80);
      idle(4);
      chk({7'h00, core_reset}, 8'h01);
      wr(fpf_pkg::ADDR_DOR, 8'h0C);
      idle(3);
      // polled read at a random threshold
      {spec_load, spec_non_dma} = 2'b11;
      idle(1);
      spec_load = 1'b0;
      thr = $urandom_range(15, 1);
      cmd(1'b0, 4'(thr - 1));
      for (int i = 0; i < 16 - thr; i++) begin
         chk({7'h00, irq}, 8'h00);
         buf_q.push_back(8'($urandom));
         @(negedge clk);
         {disk_byte_valid, disk_byte} = {1'b1, buf_q[$]};
         @(negedge clk);
         {disk_byte_valid, disk_byte} = {1'b0, ~buf_q[$]};
      end
      idle(3);
      chk({7'h00, irq}, 8'h01);
      while (buf_q.size() > 0) begin
         wait_rqm(1'b1);
         rd(fpf_pkg::ADDR_DATA);
         chk(q, buf_q.pop_front());
      end
      idle(3);
      chk({7'h00, irq}, 8'h00);
      err_v = 9'($urandom);
      err_v.bad_cyl_seen = 1'b1;
      results(fpf_pkg::IC_ABNORMAL, 1'b0);
      // dma write, fill, drain to threshold, stop on terminal count
      {spec_load, spec_non_dma} = 2'b10;
      idle(1);
      spec_load = 1'b0;
      id_track = cur_track;
      err_v = '0;
      thr = $urandom_range(16, 1);
      cmd(1'b1, 4'(thr - 1));
      idle(3);
      chk({7'h00, dma_request}, 8'h01);
      for (int i = 0; i < 16; i++) begin
         buf_q.push_back(8'($urandom));
         host.cyc(1'b0, 3'h0, buf_q[$], 1'b1, 1'b0, q);
      end
      idle(3);
      chk({7'h00, dma_request}, 8'h00);
      for (int i = 0; i < thr - 1; i++) pop();
      idle(3);
      chk({7'h00, dma_request}, 8'h00);
      pop();
      idle(3);
      chk({7'h00, dma_request}, 8'h01);
      buf_q.push_back(8'($urandom));
      host.cyc(1'b0, 3'h0, buf_q[$], 1'b1, 1'b1, q);
      idle(3);
      chk({7'h00, dma_request}, 8'h00);
      while (buf_q.size() > 0) pop();
      results(fpf_pkg::IC_NORMAL, 1'b1);
      wrap_up();
   end
endmodule

// ---- tb/fpf_host.sv ----
// host processor and dma controller model on the sequencer's bus pins
`timescale 1ns/1ns
module fpf_host (
   // clock
   input wire logic clk,
   // bus towards the device
   output logic [2:0] addr,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic [7:0] data_in,
   output logic dma_acknowledge_n,
   output logic terminal_count,
   // read data back from the device
   input wire logic [7:0] data_out
);
   // ********
   // idle bus levels
   // ********
   initial begin
      addr = 3'h0;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      data_in = 8'h00;
      dma_acknowledge_n = 1'b1;
      terminal_count = 1'b0;
   end
   // ********
   // one bus cycle
   // ********
   // polled by caller, ack plus strobes, late drop tolerated
   task automatic cyc(input logic rd, input logic [2:0] a, input logic [7:0] d, input logic dack,
                      input logic tc, output logic [7:0] q);
      @(negedge clk);
      addr = a;
      data_in = d;
      dma_acknowledge_n = !dack;
      terminal_count = tc;
      if (rd) begin
         read_strobe_n = 1'b0;
      end else begin
         write_strobe_n = 1'b0;
      end
      // strobe taken and answer registered at the first edge, the second edge only adds margin
      repeat (2) @(posedge clk);
      @(negedge clk);
      q = data_out;
      read_strobe_n = 1'b1;
      write_strobe_n = 1'b1;
      dma_acknowledge_n = 1'b1;
      terminal_count = 1'b0;
      data_in = ~d; // released bus no longer shows the old byte
   endtask
endmodule

// ---- verilog/fpf_ctrl.sv ----
// phase sequencer, data fifo and status byte encoder
`timescale 1ns/1ns
// ****************
// What this block does
// - status1 bit7 end of track, bits 6,3 zero
// - status1 bit5 on id or data crc
// - status1 bit4 on overrun or underrun
// - status1 bit2 when sector not found
// - status1 bit1 write protect, bit0 missing mark
// - status2 bit6 on data mark type mismatch
// - status2 bit5 on data field crc
// - status2 bit4 wrong track, bit1 bad track
// - status3 shows drive lines, bits 5,3 one
// - any reset ends work and returns idle
// - pin reset sets control reset bit, keeps specify
// - rate reset self clears, control reset dominates
// - interface select enables dma bit, active-high tc
// - command bytes need request 1, direction 0
// - pio read requests at sixteen minus threshold
// - pio write requests until full, then threshold
// - dma read request at threshold, drop when empty
// - dma write request, dropped by qualified tc
// - transfers end on tc, overrun or track end
// - result read with request and direction one
// - main status bit7 request, bit6 direction
// - interrupt code encodes only 00 normal and 01 abnormal
// ****************
module fpf_ctrl #(
   parameter int DEPTH = 16,
   parameter int CMD_BYTES = 9,
   parameter int RES_BYTES = 7
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // host bus
   input wire logic [2:0] addr,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_n,
   // dma and interrupt
   input wire logic dma_acknowledge_n,
   input wire logic terminal_count,
   output logic dma_request,
   output logic irq,
   input wire logic interface_select,
   // disk side
   input wire logic disk_byte_valid,
   input wire logic [7:0] disk_byte,
   input wire logic disk_sector_last,
   input wire logic disk_take,
   input wire logic disk_done,
   input wire fpf_pkg::fpf_err_s disk_err,
   input wire logic [7:0] id_track,
   input wire logic [7:0] cur_track,
   input wire logic write_protect_in,
   input wire logic track_zero_input,
   input wire logic head_select_output,
   input wire logic [1:0] drive_select_bits,
   // configuration
   input wire logic cfg_load,
   input wire logic cfg_fifo_en,
   input wire logic [3:0] cfg_fifo_threshold_field,
   input wire logic spec_load,
   input wire logic spec_non_dma,
   input wire logic cmd_is_write,
   input wire logic cmd_has_exec,
   // core outputs
   output logic [7:0] disk_wr_byte,
   output logic core_reset,
   output logic polling_en
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);

   fpf_pkg::fpf_phase_e ph_r, ph_nxt;
   logic [7:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [3:0] bc_r, bc_nxt;
   logic [7:0] dor_r, dor_nxt;
   logic dsr_rst_r, dsr_rst_nxt;
   logic fifo_en_r, fifo_en_nxt;
   logic [3:0] thr_r, thr_nxt;
   logic non_dma_r, non_dma_nxt;
   logic rqm_r, rqm_nxt;
   logic req_r, req_nxt;
   logic last_r, last_nxt;
   logic tc_seen_r, tc_seen_nxt;
   logic ovr_r, ovr_nxt;
   fpf_pkg::fpf_err_s err_r, err_nxt;
   logic [7:0] dout_r, dout_nxt;
   logic [7:0] st0, st1, st2, st3, res_byte;
   logic [CW-1:0] thr_eff, lvl;
   logic rd, wr, acc_data, dma_sel, tc_act, push, pop, host_side_pop, host_side_push;
   logic wr_prev_r, rd_prev_r;

   // strobe edges; a data cycle is the data address or, in select mode, an acknowledge alone
   // acknowledge alone reaches fifo only with interface select high
   assign dma_sel = interface_select && !dma_acknowledge_n;
   assign acc_data = (addr == fpf_pkg::ADDR_DATA) || dma_sel;
   assign rd = !read_strobe_n && rd_prev_r;
   assign wr = !write_strobe_n && wr_prev_r;
   assign tc_act = interface_select ? terminal_count : !terminal_count;
   // any reset source holds the core
   // control bit dominates self-clearing rate bit
   assign core_reset = reset || !dor_r[fpf_pkg::DOR_RESET_BIT] || dsr_rst_r;
   // effective threshold is field plus one
   assign thr_eff = CW'(thr_r) + CW'(1);
   assign lvl = CW'(DEPTH) - thr_eff;
   assign host_side_pop = rd && acc_data && (ph_r == fpf_pkg::FPF_EXEC_RD);
   assign host_side_push = wr && acc_data && (ph_r == fpf_pkg::FPF_EXEC_WR);
   assign push = (ph_r == fpf_pkg::FPF_EXEC_RD) ? (disk_byte_valid && cnt_r != CW'(DEPTH)) : host_side_push;
   assign pop = (ph_r == fpf_pkg::FPF_EXEC_RD) ? host_side_pop : (disk_take && cnt_r != '0);
   assign disk_wr_byte = mem_r[rp_r];

   // status byte encoding
   always_comb begin
      st0 = {(ovr_r || !tc_seen_r) ? fpf_pkg::IC_ABNORMAL : fpf_pkg::IC_NORMAL, 3'h0, head_select_output,
         drive_select_bits};
      st1 = {err_r.end_of_track || !tc_seen_r, 1'b0, err_r.id_crc || err_r.data_crc, ovr_r, 1'b0,
         err_r.no_data, err_r.wp_hit, err_r.no_id_mark || err_r.no_data_mark};
      st2 = {1'b0, err_r.mark_mismatch, err_r.data_crc, err_r.bad_cyl_seen, 2'h0,
         err_r.bad_cyl_seen && (id_track == fpf_pkg::BAD_TRACK), err_r.no_data_mark};
      st3 = {1'b0, write_protect_in, 1'b1, track_zero_input, 1'b1, head_select_output, drive_select_bits};
      case (bc_r)
         4'h0: res_byte = st0;
         4'h1: res_byte = st1;
         4'h2: res_byte = st2;
         4'h3: res_byte = st3;
         default: res_byte = cur_track;
      endcase
   end

   // phase, fifo and register next state
   always_comb begin
      ph_nxt = ph_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      bc_nxt = bc_r;
      dor_nxt = dor_r;
      dsr_rst_nxt = 1'b0;
      fifo_en_nxt = fifo_en_r;
      thr_nxt = thr_r;
      non_dma_nxt = non_dma_r;
      rqm_nxt = rqm_r;
      req_nxt = req_r;
      last_nxt = last_r;
      tc_seen_nxt = tc_seen_r;
      ovr_nxt = ovr_r;
      err_nxt = err_r | disk_err;
      dout_nxt = dout_r;
      if (wr && addr == fpf_pkg::ADDR_DOR && !dma_sel) begin
         dor_nxt = data_in;
      end
      if (wr && addr == fpf_pkg::ADDR_MSR_DSR && !dma_sel) begin
         dsr_rst_nxt = data_in[fpf_pkg::DSR_RESET_BIT];
      end
      if (spec_load) begin
         non_dma_nxt = spec_non_dma;
      end
      if (cfg_load) begin
         fifo_en_nxt = cfg_fifo_en;
         thr_nxt = cfg_fifo_threshold_field;
      end
      if (push) begin
         wp_nxt = wp_r + AW'(1);
      end
      if (pop) begin
         rp_nxt = rp_r + AW'(1);
      end
      cnt_nxt = cnt_r + CW'(push) - CW'(pop);
      if (disk_sector_last && disk_byte_valid) begin
         last_nxt = 1'b1;
      end
      if (tc_act && (!dma_acknowledge_n || !interface_select)) begin
         tc_seen_nxt = 1'b1;
      end
      // disk byte with full fifo or write fifo starved
      if ((ph_r == fpf_pkg::FPF_EXEC_RD && disk_byte_valid && cnt_r == CW'(DEPTH)) ||
         (ph_r == fpf_pkg::FPF_EXEC_WR && disk_take && cnt_r == '0 && !tc_seen_r)) begin
         ovr_nxt = 1'b1;
      end
      if (rd && addr == fpf_pkg::ADDR_DATA) begin
         dout_nxt = (ph_r == fpf_pkg::FPF_RESULT) ? res_byte : mem_r[rp_r];
      end else if (rd && addr == fpf_pkg::ADDR_MSR_DSR) begin
         dout_nxt = 8'h00;
         dout_nxt[fpf_pkg::MSR_RQM_BIT] = rqm_r;
         dout_nxt[fpf_pkg::MSR_DIO_BIT] = (ph_r == fpf_pkg::FPF_RESULT) || (ph_r == fpf_pkg::FPF_EXEC_RD);
         dout_nxt[fpf_pkg::MSR_NDMA_BIT] = non_dma_r && (ph_r == fpf_pkg::FPF_EXEC_RD || ph_r == fpf_pkg::FPF_EXEC_WR);
         dout_nxt[fpf_pkg::MSR_CB_BIT] = (ph_r != fpf_pkg::FPF_IDLE);
      end
      case (ph_r)
         fpf_pkg::FPF_IDLE: begin
            // command byte accepted only with request high
            rqm_nxt = 1'b1;
            req_nxt = 1'b0;
            if (wr && addr == fpf_pkg::ADDR_DATA && rqm_r) begin
               ph_nxt = fpf_pkg::FPF_CMD;
               bc_nxt = 4'h1;
               rqm_nxt = 1'b0;
               err_nxt = '0;
               ovr_nxt = 1'b0;
               tc_seen_nxt = 1'b0;
               last_nxt = 1'b0;
            end
         end
         fpf_pkg::FPF_CMD: begin
            // request drops per byte, fifo kept empty
            rqm_nxt = !(wr && addr == fpf_pkg::ADDR_DATA);
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
            if (wr && addr == fpf_pkg::ADDR_DATA && rqm_r) begin
               bc_nxt = bc_r + 4'h1;
               if (bc_r == 4'(CMD_BYTES - 1)) begin
                  bc_nxt = 4'h0;
                  ph_nxt = !cmd_has_exec ? fpf_pkg::FPF_IDLE :
                     cmd_is_write ? fpf_pkg::FPF_EXEC_WR : fpf_pkg::FPF_EXEC_RD;
                  rqm_nxt = 1'b0;
               end
            end
         end
         fpf_pkg::FPF_EXEC_RD: begin
            // request at level or sector end, drop on empty
            if ((fifo_en_r ? (cnt_r >= lvl) : (cnt_r != '0)) || (last_r && cnt_r != '0)) begin
               req_nxt = 1'b1;
            end
            if (cnt_nxt == '0 || (last_r && cnt_r == CW'(1) && pop)) begin
               req_nxt = 1'b0;
            end
            // end on tc, overrun or track end once drained
            if ((disk_done || tc_seen_r || ovr_r) && cnt_r == '0) begin
               ph_nxt = fpf_pkg::FPF_RESULT;
               req_nxt = 1'b1;
            end
         end
         fpf_pkg::FPF_EXEC_WR: begin
            // request from start until full, again at threshold
            // dropped by tc, qualified by acknowledge in select mode only
            if (cnt_nxt == CW'(DEPTH)) begin
               req_nxt = 1'b0;
            end else if (!fifo_en_r || cnt_r <= CW'(DEPTH) - thr_eff || cnt_r == '0) begin
               req_nxt = 1'b1;
            end
            if (tc_seen_r || ovr_r || (non_dma_r && !tc_act && dma_acknowledge_n && 1'b0)) begin
               req_nxt = 1'b0;
            end
            if (tc_seen_r || ovr_r || disk_done) begin
               ph_nxt = fpf_pkg::FPF_DRAIN;
               req_nxt = 1'b0;
            end
         end
         fpf_pkg::FPF_DRAIN: begin
            // request already down while fifo drains
            req_nxt = 1'b0;
            if (cnt_r == '0 || disk_done) begin
               ph_nxt = fpf_pkg::FPF_RESULT;
               req_nxt = 1'b1;
            end
         end
         fpf_pkg::FPF_RESULT: begin
            // results read with direction one, then idle
            rqm_nxt = 1'b1;
            if (rd && addr == fpf_pkg::ADDR_DATA && rqm_r) begin
               req_nxt = 1'b0;
               bc_nxt = bc_r + 4'h1;
               if (bc_r == 4'(RES_BYTES - 1)) begin
                  bc_nxt = 4'h0;
                  ph_nxt = fpf_pkg::FPF_IDLE;
               end
            end
         end
         default: ph_nxt = fpf_pkg::FPF_IDLE;
      endcase
      if (ph_r == fpf_pkg::FPF_EXEC_RD || ph_r == fpf_pkg::FPF_EXEC_WR) begin
         rqm_nxt = req_nxt && non_dma_r;
      end
      // rate reset clears core state, not the control register
      if (dsr_rst_r || !dor_r[fpf_pkg::DOR_RESET_BIT]) begin
         ph_nxt = fpf_pkg::FPF_IDLE;
         fifo_en_nxt = 1'b0;
         thr_nxt = fpf_pkg::THR_RESET;
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
         bc_nxt = 4'h0;
         req_nxt = 1'b0;
         rqm_nxt = 1'b0;
      end
   end

   // registers; pin reset keeps the specify setting
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= (ph_r == fpf_pkg::FPF_EXEC_RD) ? disk_byte : data_in;
      end
      wr_prev_r <= write_strobe_n;
      rd_prev_r <= read_strobe_n;
      non_dma_r <= non_dma_nxt;
      if (reset) begin
         ph_r <= fpf_pkg::FPF_IDLE;
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         bc_r <= 4'h0;
         // control reset bit set by the pin
         dor_r <= fpf_pkg::DOR_RESET_VAL;
         dsr_rst_r <= 1'b0;
         fifo_en_r <= 1'b0;
         thr_r <= fpf_pkg::THR_RESET;
         rqm_r <= 1'b0;
         req_r <= 1'b0;
         last_r <= 1'b0;
         tc_seen_r <= 1'b0;
         ovr_r <= 1'b0;
         err_r <= '0;
         dout_r <= 8'h00;
      end else begin
         ph_r <= ph_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         bc_r <= bc_nxt;
         dor_r <= dor_nxt;
         dsr_rst_r <= dsr_rst_nxt;
         fifo_en_r <= fifo_en_nxt;
         thr_r <= thr_nxt;
         rqm_r <= rqm_nxt;
         req_r <= req_nxt;
         last_r <= last_nxt;
         tc_seen_r <= tc_seen_nxt;
         ovr_r <= ovr_nxt;
         err_r <= err_nxt;
         dout_r <= dout_nxt;
      end
   end

   // pins
   assign data_out = dout_r;
   assign data_oe_n = read_strobe_n;
   // dma request gated by the dma enable bit in select mode
   assign dma_request = req_r && !non_dma_r && (!interface_select || dor_r[fpf_pkg::DOR_DMAEN_BIT]) &&
      (ph_r == fpf_pkg::FPF_EXEC_RD || ph_r == fpf_pkg::FPF_EXEC_WR);
   // interrupt follows request in non-dma execution and in results; the idle tc and acknowledge term never masks it
   assign irq = req_r && (non_dma_r || ph_r == fpf_pkg::FPF_RESULT) &&
      !(ph_r == fpf_pkg::FPF_EXEC_WR && !tc_act && dma_acknowledge_n && !non_dma_r);
   assign polling_en = !core_reset;

   // ****************
   // checks
   // ****************
   property p_fifo_bound;
      @(posedge clk) disable iff (reset) cnt_r <= CW'(DEPTH);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
   property p_pin_reset;
      @(posedge clk) $fell(reset) |-> !dor_r[fpf_pkg::DOR_RESET_BIT] && core_reset;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset did not set control reset");
   property p_dsr_clear;
      @(posedge clk) disable iff (reset) dsr_rst_r |=> !dsr_rst_r || $past(wr);
   endproperty
   a_dsr_clear: assert property (p_dsr_clear) else $error("rate reset did not clear");
   property p_reset_idle;
      @(posedge clk) disable iff (reset) core_reset |=> ph_r == fpf_pkg::FPF_IDLE;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("reset did not return to idle");
   property p_cmd_rqm;
      @(posedge clk) disable iff (reset || core_reset)
         (ph_r == fpf_pkg::FPF_CMD && wr && addr == fpf_pkg::ADDR_DATA) |=> !rqm_r;
   endproperty
   a_cmd_rqm: assert property (p_cmd_rqm) else $error("request stayed high after command byte");
   property p_st3_fixed;
      @(posedge clk) disable iff (reset) st3[5] && st3[3] && !st3[7];
   endproperty
   a_st3_fixed: assert property (p_st3_fixed) else $error("status3 fixed bits wrong");
   property p_rd_empty;
      @(posedge clk) disable iff (reset || core_reset)
         (ph_r == fpf_pkg::FPF_EXEC_RD && cnt_r == '0 && ph_nxt == ph_r) |=> !req_r;
   endproperty
   a_rd_empty: assert property (p_rd_empty) else $error("read request while fifo empty");
   // last result byte taken, then idle with the request raised again
   sequence s_last_result;
      ph_r == fpf_pkg::FPF_RESULT && bc_r == 4'(RES_BYTES - 1) && rd && addr == fpf_pkg::ADDR_DATA && rqm_r;
   endsequence
   sequence s_idle_ready;
      ph_r == fpf_pkg::FPF_IDLE ##1 rqm_r;
   endsequence
   property p_result_idle;
      @(posedge clk) disable iff (reset || core_reset)
         s_last_result |=> s_idle_ready;
   endproperty
   a_result_idle: assert property (p_result_idle) else $error("result end did not reach idle");
endmodule

// ---- verilog/fpf_pkg.sv ----
// shared constants and types for the floppy phase and fifo sequencer
package fpf_pkg;
   // ****************
   // register addresses (low three address bits)
   // ****************
   localparam logic [2:0] ADDR_DOR = 3'h2;
   localparam logic [2:0] ADDR_MSR_DSR = 3'h4;
   localparam logic [2:0] ADDR_DATA = 3'h5;
   // ****************
   // field positions
   // ****************
   localparam int MSR_RQM_BIT = 7;
   localparam int MSR_DIO_BIT = 6;
   localparam int MSR_NDMA_BIT = 5;
   localparam int MSR_CB_BIT = 4;
   localparam int DOR_RESET_BIT = 2;
   localparam int DOR_DMAEN_BIT = 3;
   localparam int DSR_RESET_BIT = 7;
   // ****************
   // fifo and status constants
   // ****************
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] BAD_TRACK = 8'hFF;
   localparam logic [1:0] IC_NORMAL = 2'h0;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam logic [1:0] IC_INVALID = 2'h2;
   localparam logic [1:0] IC_POLL = 2'h3;
   localparam logic [3:0] THR_RESET = 4'h0;
   // reset bit low: the core stays held until the host writes it high
   localparam logic [7:0] DOR_RESET_VAL = 8'h00;
   // ****************
   // phases
   // ****************
   typedef enum logic [2:0] {FPF_IDLE, FPF_CMD, FPF_EXEC_RD, FPF_EXEC_WR, FPF_DRAIN, FPF_RESULT} fpf_phase_e;
   // disk-side error events of one command
   typedef struct packed {
      logic end_of_track;
      logic id_crc;
      logic data_crc;
      logic no_data;
      logic wp_hit;
      logic no_id_mark;
      logic no_data_mark;
      logic mark_mismatch;
      logic bad_cyl_seen;
   } fpf_err_s;
endpackage
